// ===== src/tef_pkg.sv
package tef_pkg;
    localparam int NCH = 2;
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_MOD = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_CNT = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_CH_BASE = 8'h10;
    localparam logic [ADDR_W-1:0] CH_STRIDE = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_CH_CTL = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_CH_VAL = 8'h04;
    // control register fields
    localparam int CTRL_RUN_BIT = 0;
    localparam int CTRL_CAS_BIT = 1;
    localparam int CTRL_WIE_BIT = 2;
    localparam int FLAG_BIT = 7;
    // channel control fields
    localparam int CHC_ELS_LO = 0;
    localparam int CHC_MODE_LO = 2;
    localparam int CHC_IE_BIT = 4;
    localparam logic [2:0] CTRL_RST = 3'h0;
    localparam logic [4:0] CHC_RST = 5'h00;
    localparam logic [15:0] ZERO16 = 16'h0000;
    localparam logic [15:0] MAX16 = 16'hFFFF;
    localparam logic [15:0] ONE16 = 16'h0001;
    localparam logic [1:0] MODE_CAPT = 2'h0;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ===== src/tef_top.sv
// Decided for this implementation: the register offsets and register access over AXI4-Lite.
`timescale 1ns/100ps
module tef_top (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [tef_pkg::ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [tef_pkg::ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic [tef_pkg::NCH-1:0] capture_in,
    output logic irq
);
    import tef_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // functions
    function automatic logic ch_hit(input logic [ADDR_W-1:0] a, input int n,
                                    input logic [ADDR_W-1:0] ofs);
        return a == ADDR_W'(OFS_CH_BASE + n * CH_STRIDE + ofs);
    endfunction

    function automatic logic [15:0] wmerge(input logic [15:0] old,
                                           input logic [31:0] d,
                                           input logic [3:0] s);
        return {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    endfunction

    // returns {flag, arm}
    function automatic logic [1:0] flag_step(input logic flag, input logic arm,
                                             input logic evt, input logic rd,
                                             input logic wr, input logic wbit);
        logic clr;
        logic f;
        logic a;
        clr = arm & wr & ~wbit;
        f = evt | (flag & ~clr);
        a = ~evt & ((rd & flag) | (arm & ~wr));
        return {f, a};
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // state
    logic acc_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic arready_r;
    logic rvalid_r;
    logic [1:0] rresp_r;
    logic [31:0] rdata_r;
    logic irq_r;
    logic [2:0] ctrl_r;
    logic [15:0] mod_r;
    logic [15:0] cnt_r;
    logic down_r;
    logic wrap_flag_r;
    logic wrap_arm_r;
    logic [4:0] chc_r [NCH];
    logic [15:0] chv_r [NCH];
    logic [NCH-1:0] ch_flag_r;
    logic [NCH-1:0] ch_arm_r;
    logic [NCH-1:0] cap_s1_r;
    logic [NCH-1:0] cap_s2_r;
    logic [NCH-1:0] cap_d_r;

    ////////////////////////////////////////////////////////////////////////
    // bus decode
    wire wr_fire = acc_r & awvalid & wvalid;
    wire rd_fire = arready_r & arvalid;
    wire lane0 = wstrb[0];
    wire wr_sel_ctrl = awaddr == OFS_CTRL;
    wire wr_sel_mod = awaddr == OFS_MOD;
    wire wr_sel_cnt = awaddr == OFS_CNT;
    wire rd_sel_ctrl = araddr == OFS_CTRL;
    wire rd_sel_mod = araddr == OFS_MOD;
    wire rd_sel_cnt = araddr == OFS_CNT;
    wire wr_ctrl = wr_fire & wr_sel_ctrl;
    wire wr_mod = wr_fire & wr_sel_mod;
    wire wr_cnt = wr_fire & wr_sel_cnt;
    wire rd_ctrl = rd_fire & rd_sel_ctrl;
    logic [NCH-1:0] wr_chc;
    logic [NCH-1:0] wr_chv;
    logic [NCH-1:0] rd_chc;
    logic [NCH-1:0] wr_ch_any;
    logic [NCH-1:0] rd_ch_any;
    always_comb begin
        for (int i = 0; i < NCH; i++) begin
            wr_chc[i] = wr_fire & ch_hit(awaddr, i, OFS_CH_CTL);
            wr_chv[i] = wr_fire & ch_hit(awaddr, i, OFS_CH_VAL);
            rd_chc[i] = rd_fire & ch_hit(araddr, i, OFS_CH_CTL);
            wr_ch_any[i] = ch_hit(awaddr, i, OFS_CH_CTL) | ch_hit(awaddr, i, OFS_CH_VAL);
            rd_ch_any[i] = ch_hit(araddr, i, OFS_CH_CTL) | ch_hit(araddr, i, OFS_CH_VAL);
        end
    end
    wire wr_map = wr_sel_ctrl | wr_sel_mod | wr_sel_cnt
                  | (|wr_ch_any);
    wire rd_map = rd_sel_ctrl | rd_sel_mod | rd_sel_cnt
                  | (|rd_ch_any);

    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h00000000;
        if (araddr == OFS_CTRL) begin
            rd_mux[FLAG_BIT] = wrap_flag_r;
            rd_mux[2:0] = ctrl_r;
        end
        if (araddr == OFS_MOD) begin
            rd_mux[15:0] = mod_r;
        end
        if (araddr == OFS_CNT) begin
            rd_mux[15:0] = cnt_r;
        end
        for (int i = 0; i < NCH; i++) begin
            if (ch_hit(araddr, i, OFS_CH_CTL)) begin
                rd_mux[FLAG_BIT] = ch_flag_r[i];
                rd_mux[4:0] = chc_r[i];
            end
            if (ch_hit(araddr, i, OFS_CH_VAL)) begin
                rd_mux[15:0] = chv_r[i];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // counter
    wire run = ctrl_r[CTRL_RUN_BIT];
    wire center = ctrl_r[CTRL_CAS_BIT];
    wire [15:0] top = (mod_r == ZERO16) ? MAX16 : mod_r;
    wire at_top = ~down_r & (cnt_r == mod_r);
    wire at_bot = down_r & (cnt_r == ZERO16);
    wire dir_nxt = at_top ? 1'b1 : (at_bot ? 1'b0 : down_r);
    wire lin_wrap = cnt_r == top;
    wire wrap_evt = run & (center ? at_top : lin_wrap);
    logic [15:0] cnt_nxt;
    always_comb begin
        cnt_nxt = cnt_r;
        if (wr_cnt) begin
            cnt_nxt = ZERO16;
        end else if (run && center) begin
            cnt_nxt = dir_nxt ? cnt_r - ONE16 : cnt_r + ONE16;
        end else if (run) begin
            cnt_nxt = lin_wrap ? ZERO16 : cnt_r + ONE16;
        end
    end
    wire down_nxt = wr_cnt ? 1'b0 : ((run & center) ? dir_nxt : 1'b0);

    ////////////////////////////////////////////////////////////////////////
    // channel events
    wire [NCH-1:0] rise = cap_s2_r & ~cap_d_r;
    wire [NCH-1:0] fall = ~cap_s2_r & cap_d_r;
    logic [NCH-1:0] capt_mode;
    logic [NCH-1:0] ch_evt;
    logic [NCH-1:0] cap_evt;
    always_comb begin
        for (int i = 0; i < NCH; i++) begin
            capt_mode[i] = ~center & (chc_r[i][CHC_MODE_LO+:2] == MODE_CAPT);
            cap_evt[i] = capt_mode[i] & ((chc_r[i][CHC_ELS_LO] & rise[i])
                         | (chc_r[i][CHC_ELS_LO+1] & fall[i]));
            // compare, edge pwm and both center pwm matches
            ch_evt[i] = capt_mode[i] ? cap_evt[i]
                        : (run & (cnt_r == chv_r[i]));
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // flags and interrupt
    wire [1:0] wrap_step = flag_step(wrap_flag_r, wrap_arm_r, wrap_evt, rd_ctrl,
                                     wr_ctrl & lane0, wdata[FLAG_BIT]);
    logic [NCH-1:0] ch_flag_nxt;
    logic [NCH-1:0] ch_arm_nxt;
    logic [NCH-1:0] ch_ie;
    logic [1:0] st;
    always_comb begin
        st = 2'h0;
        for (int i = 0; i < NCH; i++) begin
            st = flag_step(ch_flag_r[i], ch_arm_r[i], ch_evt[i], rd_chc[i],
                           wr_chc[i] & lane0, wdata[FLAG_BIT]);
            ch_flag_nxt[i] = st[1];
            ch_arm_nxt[i] = st[0];
            ch_ie[i] = chc_r[i][CHC_IE_BIT];
        end
    end
    wire irq_nxt = (wrap_flag_r & ctrl_r[CTRL_WIE_BIT]) | (|(ch_flag_r & ch_ie));

    ////////////////////////////////////////////////////////////////////////
    // registers
    wire [15:0] ctrl_wm = wmerge({13'h0000, ctrl_r}, wdata, wstrb);
    logic [15:0] chc_wm [NCH];
    always_comb begin
        for (int i = 0; i < NCH; i++) begin
            chc_wm[i] = wmerge({11'h000, chc_r[i]}, wdata, wstrb);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_r <= CTRL_RST;
            mod_r <= ZERO16;
        end else begin
            if (wr_ctrl) begin
                ctrl_r <= ctrl_wm[2:0];
            end
            if (wr_mod) begin
                mod_r <= wmerge(mod_r, wdata, wstrb);
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_r <= ZERO16;
            down_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            down_r <= down_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // wrap flag and request
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wrap_flag_r <= 1'b0;
            wrap_arm_r <= 1'b0;
            irq_r <= 1'b0;
        end else begin
            wrap_flag_r <= wrap_step[1];
            wrap_arm_r <= wrap_step[0];
            irq_r <= irq_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // channel registers
    always_ff @(posedge aclk) begin
        for (int i = 0; i < NCH; i++) begin
            if (!aresetn) begin
                chc_r[i] <= CHC_RST;
                chv_r[i] <= ZERO16;
            end else begin
                if (wr_chc[i]) begin
                    chc_r[i] <= chc_wm[i][4:0];
                end
                if (wr_chv[i]) begin
                    chv_r[i] <= wmerge(chv_r[i], wdata, wstrb);
                end else if (cap_evt[i]) begin
                    chv_r[i] <= cnt_r;
                end
            end
        end
    end

    always_ff @(posedge aclk) begin
        for (int i = 0; i < NCH; i++) begin
            if (!aresetn) begin
                ch_flag_r[i] <= 1'b0;
                ch_arm_r[i] <= 1'b0;
            end else begin
                ch_flag_r[i] <= ch_flag_nxt[i];
                ch_arm_r[i] <= ch_arm_nxt[i];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // capture pin synchroniser
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cap_s1_r <= '0;
            cap_s2_r <= '0;
        end else begin
            cap_s1_r <= capture_in;
            cap_s2_r <= cap_s1_r;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cap_d_r <= '0;
        end else begin
            cap_d_r <= cap_s2_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // axi4-lite handshakes
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            acc_r <= 1'b0;
            bvalid_r <= 1'b0;
            bresp_r <= RESP_OKAY;
        end else begin
            acc_r <= ~acc_r & ~bvalid_r & awvalid & wvalid;
            if (wr_fire) begin
                bvalid_r <= 1'b1;
                bresp_r <= wr_map ? RESP_OKAY : RESP_SLVERR;
            end else if (bready) begin
                bvalid_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_r <= 1'b0;
            rvalid_r <= 1'b0;
            rresp_r <= RESP_OKAY;
            rdata_r <= 32'h00000000;
        end else begin
            arready_r <= ~arready_r & ~rvalid_r & arvalid;
            if (rd_fire) begin
                rvalid_r <= 1'b1;
                rresp_r <= rd_map ? RESP_OKAY : RESP_SLVERR;
                rdata_r <= rd_mux;
            end else if (rready) begin
                rvalid_r <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs
    assign awready = acc_r;
    assign wready = acc_r;
    assign bvalid = bvalid_r;
    assign bresp = bresp_r;
    assign arready = arready_r;
    assign rvalid = rvalid_r;
    assign rresp = rresp_r;
    assign rdata = rdata_r;
    assign irq = irq_r;
endmodule

// ===== sim/tef_top_asserts.sv
`timescale 1ns/100ps
module tef_top_asserts (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic awvalid,
    input wire logic awready,
    input wire logic wvalid,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    input wire logic bready,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic rvalid,
    input wire logic rready,
    input wire logic irq
);
    import tef_pkg::*;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_wr;
        awready && awvalid && wvalid;
    endsequence
    sequence s_rd;
        arready && arvalid;
    endsequence
    property p_rst;
        disable iff (1'b0) !aresetn |=> !bvalid && !rvalid && !irq;
    endproperty
    property p_b_after;
        s_wr |=> bvalid && !awready;
    endproperty
    property p_r_after;
        s_rd |=> rvalid && !arready;
    endproperty
    property p_b_hold;
        bvalid && !bready |=> bvalid && $stable(bresp);
    endproperty
    property p_r_hold;
        rvalid && !rready |=> rvalid && $stable(rdata);
    endproperty
    property p_aw_pulse;
        awready |-> !bvalid ##1 !awready;
    endproperty
    property p_ar_free;
        arready |-> !rvalid;
    endproperty
    property p_irq_fall;
        $fell(irq) |-> bvalid || $past(bvalid);
    endproperty
    a_rst: assert property (p_rst) else $error("outputs busy after reset");
    a_b_after: assert property (p_b_after) else $error("no write answer");
    a_r_after: assert property (p_r_after) else $error("no read answer");
    a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
    a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
    a_aw_pulse: assert property (p_aw_pulse) else $error("write ready misused");
    a_ar_free: assert property (p_ar_free) else $error("read taken while busy");
    a_irq_fall: assert property (p_irq_fall) else $error("irq fell without write");
endmodule
bind tef_top tef_top_asserts i_tef_top_asserts (.aclk(aclk), .aresetn(aresetn),
    .awvalid(awvalid), .awready(awready), .wvalid(wvalid), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rvalid(rvalid),
    .rready(rready), .irq(irq));

// ===== sim/tef_top_test.sv
`timescale 1ns/100ps
module tef_top_test;
    import tef_pkg::*;
    logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, irq;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rd_d;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, capture_in, b_last, r_last;
    int fails, checked, cyc;
    tef_top i_tef_top (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .capture_in(capture_in), .irq(irq));
    ////////////////////////////////////////
    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 90000) begin
            fails = fails + 1;
            test_done();
        end
    end
    task automatic test_done();
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checked = checked + 1;
        if (g !== e) begin
            fails = fails + 1;
            $display("unexpected at %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic rst();
        aresetn <= 1'b0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        @(posedge aclk);
        while (awready !== 1'b1) @(posedge aclk);
        awvalid <= 1'b0;
        wvalid <= 1'b0;
        while (bvalid !== 1'b1) @(posedge aclk);
        b_last = bresp;
        bready <= 1'b0;
        @(posedge aclk);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        @(posedge aclk);
        while (arready !== 1'b1) @(posedge aclk);
        arvalid <= 1'b0;
        while (rvalid !== 1'b1) @(posedge aclk);
        d = rdata;
        r_last = rresp;
        rready <= 1'b0;
        @(posedge aclk);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] re);
        logic [31:0] d;
        rd(a, d);
        chk(d, e);
        chk({30'h0, r_last}, {30'h0, re});
    endtask
    task automatic poll(input logic [7:0] a);
        rd_d = 32'h0;
        while (rd_d[FLAG_BIT] !== 1'b1) rd(a, rd_d);
    endtask
    ////////////////////////////////////////
    initial begin
        cyc = 0;
        fails = 0;
        checked = 0;
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
        {awaddr, araddr, wdata} = 48'h0;
        wstrb = 4'h3;
        capture_in = 2'h0;
        rst();
        rdc(OFS_CTRL, 32'h0, RESP_OKAY);
        rdc(8'h18, 32'h0, RESP_OKAY);
        rdc(8'hF0, 32'h0, RESP_SLVERR);
        wr(8'hF0, 32'h1);
        chk({30'h0, b_last}, {30'h0, RESP_SLVERR});
        $display("test reset done");
        wr(OFS_MOD, 32'hA);
        wr(OFS_CTRL, 32'h5);
        poll(OFS_CTRL);
        chk(32'(irq), 32'h1);
        wr(OFS_CTRL, 32'h84);
        wr(OFS_CTRL, 32'h4);
        rdc(OFS_CTRL, 32'h84, RESP_OKAY);
        wr(OFS_CTRL, 32'h4);
        rdc(OFS_CTRL, 32'h4, RESP_OKAY);
        chk(32'(irq), 32'h0);
        wr(OFS_CTRL, 32'h84);
        rdc(OFS_CTRL, 32'h4, RESP_OKAY);
        wr(OFS_MOD, 32'h3);
        wr(OFS_CNT, 32'h0);
        wr(OFS_CTRL, 32'h5);
        poll(OFS_CTRL);
        wr(OFS_CTRL, 32'h5);
        rdc(OFS_CTRL, 32'h85, RESP_OKAY);
        $display("test clear done");
        rst();
        wr(OFS_MOD, 32'h14);
        wr(8'h14, 32'h5);
        wr(8'h10, 32'h14);
        wr(8'h1C, 32'h1E);
        wr(8'h18, 32'h4);
        wr(OFS_CTRL, 32'h1);
        poll(8'h10);
        chk(32'(irq), 32'h1);
        rdc(8'h18, 32'h4, RESP_OKAY);
        $display("test compare done");
        rst();
        wr(OFS_MOD, 32'h6);
        wr(8'h14, 32'h2);
        wr(OFS_CTRL, 32'h3);
        for (int i = 0; i < 8; i++) begin
            rd(OFS_CNT, rd_d);
            chk(32'(rd_d[15:0] <= 16'h6), 32'h1);
        end
        rdc(OFS_CTRL, 32'h83, RESP_OKAY);
        rdc(8'h10, 32'h80, RESP_OKAY);
        $display("test center done");
        for (int es = 0; es < 4; es++) begin
            for (int up = 0; up < 2; up++) begin
                capture_in <= (up == 1) ? 2'h0 : 2'h3;
                rst();
                wr(8'h18, 32'(es));
                capture_in <= (up == 1) ? 2'h3 : 2'h0;
                repeat (8) @(posedge aclk);
                rdc(8'h18, {24'h0, es[up == 1 ? 0 : 1], 5'h0, es[1:0]}, RESP_OKAY);
            end
        end
        $display("test capture done");
        rst();
        wr(OFS_CTRL, 32'h1);
        repeat (64990) @(posedge aclk);
        rdc(OFS_CTRL, 32'h1, RESP_OKAY);
        repeat (600) @(posedge aclk);
        rdc(OFS_CTRL, 32'h81, RESP_OKAY);
        $display("test free run done");
        test_done();
    end
endmodule
